// File: hw/output_sync_io_pins.sv
`timescale 1ns/100ps
// Contract
// R1: turn-on pin: sync, input or output
// R2: turn-off pin: sync, input or output
// R3: per-pin polarity for in and out
// R4: turn-on pin sends and hears pulses
// R5: off-to-on change emits turn-on pulse
// R6: turn-on pulse ignored when on
// R7: turn-on pulse switches output on
// R8: turn-off pin sends and hears pulses
// R9: on-to-off change emits turn-off pulse
// R10: turn-off pulse ignored when off
// R11: turn-off pulse switches output off
// R12: logical one drives low, inverted high
// R13: logical zero drives high, inverted low
// R14: output may carry configurable PWM
// R15: input mode samples pin level
// R16: sync pulses low at least 30us
// R17: synchronise, filter width, one event
module output_sync_io_pins
   import io_sync_pkg::*;
#(
   // Minimum sync pulse width in cycles
   parameter int unsigned PULSE_CYCLES = SYNC_LOW_MIN_CYC,
   // PWM counter width
   parameter int unsigned PWM_BITS     = PWM_W
)
(
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                reset,
   // Register port
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [DATA_W-1:0]   reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [DATA_W-1:0]   reg_rdata,
   // Front-panel switch requests
   input  wire logic                panel_on_req,
   input  wire logic                panel_off_req,
   // Output enable state
   output logic                     out_on,
   // Sync and general pins
   input  wire logic [NUM_PINS-1:0] pin_i,
   output logic      [NUM_PINS-1:0] pin_o,
   output logic      [NUM_PINS-1:0] pin_oe,
   // Sampled general input levels
   output logic      [NUM_PINS-1:0] gp_level
);

   // Output enable state
   logic                out_on_q;
   logic                out_on_d;

   // Registered read data
   logic [DATA_W-1:0]   rdata_q;

   // Per-pin setup and PWM values
   pin_cfg_t            cfg_q    [NUM_PINS];
   logic [PWM_BITS-1:0] period_q [NUM_PINS];
   logic [PWM_BITS-1:0] duty_q   [NUM_PINS];

   // Per-pin pin drivers
   logic [NUM_PINS-1:0] pin_o_q;
   logic [NUM_PINS-1:0] pin_oe_q;

   // Per-pin signals from the filters
   logic [NUM_PINS-1:0] in_lvl;     // Level after polarity
   logic [NUM_PINS-1:0] in_evt;     // Accepted sync pulse
   logic [NUM_PINS-1:0] tx_busy;    // Own pulse being driven
   logic [NUM_PINS-1:0] tx_send;    // Start own pulse
   logic [NUM_PINS-1:0] is_sync;    // Pin in sync function
   logic [NUM_PINS-1:0] pwm_level;  // PWM waveform per pin

   // Read contributions, OR-ed into one word
   logic [DATA_W-1:0]   pin_rd   [NUM_PINS];
   logic [DATA_W-1:0]   rd_or    [NUM_PINS+1];

   // Status word seen by software
   status_t             status;

   assign status.in_level = in_lvl;
   assign status.out_on   = out_on_q;

   // Flat map: status, one setup word per pin, then period and duty per pin.
   // Addresses compare in full, so an alias of a mapped word reads zero
   // and drops writes.
   // Status register decode
   wire stat_hit = (reg_addr == REG_STATUS);

   // Turn-on and turn-off side events
   // R7: received pulse turns output on
   wire rx_on  = in_evt[PIN_TURN_ON] & is_sync[PIN_TURN_ON] & ~out_on_q;
   // R11: received pulse turns output off
   wire rx_off = in_evt[PIN_TURN_OFF] & is_sync[PIN_TURN_OFF] & out_on_q;

   // A received pulse counts only while its pin is in sync function;
   // in input or output function the filter result is ignored here,
   // so a level input cannot toggle the output by accident.
   // Either source may switch the state
   wire go_on  = panel_on_req | rx_on;
   wire go_off = panel_off_req | rx_off;

   // A panel request and a received pulse may land in one cycle.
   // Turning off is taken when both ask, so an off is never lost
   // behind an on that arrived together with it.
   // Off wins a clash, the safer of the two outcomes.
   // R6: turn-on pulse ignored when on
   // R10: turn-off pulse ignored when off
   assign out_on_d = go_off ? 1'b0 : (go_on ? 1'b1 : out_on_q);

   // Own pulses follow the state change itself, whatever caused it,
   // so a pulse from a partner is passed on down a chain of linked
   // units. The partner ignores our echo because its own state
   // already matches.
   // R5: pulse on off-to-on change
   assign tx_send[PIN_TURN_ON]  = is_sync[PIN_TURN_ON] & ~out_on_q & out_on_d;
   // R9: pulse on on-to-off change
   assign tx_send[PIN_TURN_OFF] = is_sync[PIN_TURN_OFF] & out_on_q & ~out_on_d;

   // Reset leaves the output off; nothing is driven onto the pins
   // until the panel or a partner asks for a change, or software selects output function.
   // Output enable state register
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         out_on_q <= 1'b0;
      end
      else
      begin
         out_on_q <= out_on_d;
      end
   end

   // Per-pin logic, one copy for each pin
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++)
      begin : g_pin

         // Each pin gets its own decode, setup words, PWM counter,
         // drive stage and input filter. The two pins differ only in
         // which state change they report and which they act on.
         // Register decode for this pin
         localparam logic [7:0] CFG_ADDR =
            8'(REG_CFG_BASE + CFG_STRIDE * gi);
         localparam logic [7:0] PER_ADDR =
            8'(REG_PWM_BASE + PWM_STRIDE * gi);
         localparam logic [7:0] DUTY_ADDR =
            8'(PER_ADDR + PWM_DUTY_OFS);

         wire cfg_hit  = (reg_addr == CFG_ADDR);
         wire per_hit  = (reg_addr == PER_ADDR);
         wire duty_hit = (reg_addr == DUTY_ADDR);

         // PWM counter
         logic [PWM_BITS-1:0] pwm_cnt_q;
         logic [PWM_BITS-1:0] pwm_cnt_d;
         logic                pwm_q;

         // Pin drive next values
         logic                drv_d;
         logic                oe_d;
         logic                logic_val;

         // R1: turn-on pin function select
         // R2: turn-off pin function select
         assign is_sync[gi] = (cfg_q[gi].mode == MODE_SYNC);

         // Read contribution, zero when not addressed
         assign pin_rd[gi] =
            cfg_hit  ? DATA_W'(cfg_q[gi])  :
            per_hit  ? DATA_W'(period_q[gi]) :
            duty_hit ? DATA_W'(duty_q[gi])   : '0;

         // Setup writes land at the strobe edge. A function change
         // reaches the pin one cycle later through the drive flops,
         // so a sync pulse in flight is cut short when software
         // leaves sync function in the middle of it.
         // Setup registers, written by software
         always_ff @(posedge core_clk)
         begin
            if (reset)
            begin
               cfg_q[gi]    <= CFG_RESET;
               period_q[gi] <= '0;
               duty_q[gi]   <= '0;
            end
            else if (reg_wr)
            begin
               if (cfg_hit)
                  cfg_q[gi] <= pin_cfg_t'(reg_wdata[CFG_W-1:0]);
               if (per_hit)
                  period_q[gi] <= reg_wdata[PWM_BITS-1:0];
               if (duty_hit)
                  duty_q[gi] <= reg_wdata[PWM_BITS-1:0];
            end
         end

         // The counter runs in every function, so switching to PWM
         // output needs no restart. Period and duty count core_clk
         // cycles. A non-zero duty not below the period keeps the value high.
         // R14: period counter wraps at period
         assign pwm_cnt_d = (pwm_cnt_q + PWM_BITS'(1) >= period_q[gi])
                            ? '0 : pwm_cnt_q + PWM_BITS'(1);

         // PWM generator; a zero period gives a steady level, high for any non-zero duty
         always_ff @(posedge core_clk)
         begin
            if (reset)
            begin
               pwm_cnt_q <= '0;
               pwm_q     <= 1'b0;
            end
            else
            begin
               pwm_cnt_q <= pwm_cnt_d;
               // R14: duty sets high share
               pwm_q     <= (pwm_cnt_q < duty_q[gi]);
            end
         end

         assign pwm_level[gi] = pwm_q;

         // Steady level and PWM share one path through the polarity
         // stage, so inversion treats both alike.
         // Logical output value, steady or PWM
         assign logic_val = cfg_q[gi].pwm_sel ? pwm_level[gi] : cfg_q[gi].level;

         // Sync pins are open-drain in style: idle they are released
         // and the pull-up of the wiring holds the line, so any unit
         // on it can pull it to the active level. Output function
         // drives both levels all the time.
         // Pin drive select per function
         always_comb
         begin
            drv_d = 1'b0;
            oe_d  = 1'b0;
            case (cfg_q[gi].mode)
               MODE_SYNC:
               begin
                  // R4: turn-on pin drives its pulse
                  // R8: turn-off pin drives its pulse
                  // R3: active level follows polarity
                  drv_d = cfg_q[gi].invert;
                  oe_d  = tx_busy[gi];
               end
               MODE_OUTPUT:
               begin
                  // R12: one drives low unless inverted
                  // R13: zero drives high unless inverted
                  drv_d = ~(logic_val ^ cfg_q[gi].invert);
                  oe_d  = 1'b1;
               end
               MODE_INPUT:
               begin
                  // Pin left to the outside driver
                  drv_d = 1'b0;
                  oe_d  = 1'b0;
               end
               default:
               begin
                  // Unused code acts as an input
                  drv_d = 1'b0;
                  oe_d  = 1'b0;
               end
            endcase
         end

         // Registered drivers keep decode glitches off the pins, at
         // the cost of one cycle of latency after each change.
         // Pin drivers come from flip-flops
         always_ff @(posedge core_clk)
         begin
            if (reset)
            begin
               pin_o_q[gi]  <= 1'b0;
               pin_oe_q[gi] <= 1'b0;
            end
            else
            begin
               pin_o_q[gi]  <= drv_d;
               pin_oe_q[gi] <= oe_d;
            end
         end

         // The filter ignores the pin while our own pulse is driven,
         // so our pulse is never taken for a partner's. A partner
         // pulse that overlaps ours is lost, which does no harm as
         // both ends then already agree.
         // Synchroniser, width filter and pulse timer
         // R16: pulse width both ways
         // R17: filtered single events
         sync_pin_filter #(
            .PULSE_CYCLES (PULSE_CYCLES)
         ) u_filter (
            .core_clk (core_clk),
            .reset    (reset),
            .pin_raw  (pin_i[gi]),
            .invert   (cfg_q[gi].invert),
            .listen   (is_sync[gi]),
            .send     (tx_send[gi]),
            .level    (in_lvl[gi]),
            .event_p  (in_evt[gi]),
            .sending  (tx_busy[gi])
         );

         // Read word chain
         assign rd_or[gi+1] = rd_or[gi] | pin_rd[gi];

      end
   endgenerate

   // Read data is an OR of per-pin words; only the addressed word
   // is non-zero, so no priority mux is needed.
   // Status word starts the read chain
   assign rd_or[0] = stat_hit ? DATA_W'(status) : '0;

   // Read data falls back to zero outside the read cycle, so a stale
   // value is never mistaken for a fresh answer.
   // Read data stands one cycle after the strobe
   // Unmapped addresses read zero, writes there are dropped
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         rdata_q <= '0;
      end
      else if (reg_rd)
      begin
         rdata_q <= rd_or[NUM_PINS];
      end
      else
      begin
         rdata_q <= '0;
      end
   end

   // The sampled level is valid in every function; software also
   // reads it through the status word.
   // Outputs
   assign reg_rdata = rdata_q;
   assign out_on    = out_on_q;
   assign pin_o     = pin_o_q;
   assign pin_oe    = pin_oe_q;
   // R15: sampled level, polarity applied
   assign gp_level  = in_lvl;

endmodule : output_sync_io_pins

// File: hw/io_sync_pkg.sv
package io_sync_pkg;

   // Pin count and the role of each pin
   localparam int unsigned NUM_PINS     = 2;
   localparam int unsigned PIN_TURN_ON  = 0;
   localparam int unsigned PIN_TURN_OFF = 1;

   // Register bus geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned PWM_W  = 16;

   // Register byte offsets
   localparam logic [7:0] REG_STATUS   = 8'h00;
   localparam logic [7:0] REG_CFG_BASE = 8'h04;
   localparam logic [7:0] CFG_STRIDE   = 8'h04;
   localparam logic [7:0] REG_PWM_BASE = 8'h0c;
   localparam logic [7:0] PWM_STRIDE   = 8'h08;
   localparam logic [7:0] PWM_DUTY_OFS = 8'h04;

   // Pin function codes
   typedef enum logic [1:0] {
      MODE_SYNC   = 2'h0,
      MODE_INPUT  = 2'h1,
      MODE_OUTPUT = 2'h2
   } pin_mode_t;

   // Per-pin setup word, low bits of the config register
   typedef struct packed {
      logic      pwm_sel;
      logic      level;
      logic      invert;
      pin_mode_t mode;
   } pin_cfg_t;

   localparam int unsigned CFG_W     = $bits(pin_cfg_t);
   localparam pin_cfg_t    CFG_RESET = '{pwm_sel: 1'b0, level: 1'b0,
                                         invert: 1'b0, mode: MODE_SYNC};

   // Status word, low bits of the status register
   typedef struct packed {
      logic [NUM_PINS-1:0] in_level;
      logic                out_on;
   } status_t;

   localparam int unsigned STAT_W = $bits(status_t);

   // Sync pulse low time and its cycle count
   localparam int unsigned CLK_PERIOD_PS    = 4000;
   localparam int unsigned SYNC_LOW_MIN_US  = 30;
   localparam int unsigned SYNC_LOW_MIN_CYC =
      (SYNC_LOW_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage : io_sync_pkg

// File: hw/sync_pin_filter.sv
`timescale 1ns/100ps
module sync_pin_filter
   import io_sync_pkg::*;
#(
   parameter int unsigned PULSE_CYCLES = SYNC_LOW_MIN_CYC
)
(
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic reset,
   // Raw pin and setup
   input  wire logic pin_raw,
   input  wire logic invert,
   input  wire logic listen,
   input  wire logic send,
   // Results
   output logic      level,
   output logic      event_p,
   output logic      sending
);

   localparam int unsigned   CW       = $clog2(PULSE_CYCLES + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(PULSE_CYCLES - 1);
   localparam logic [CW-1:0] CNT_LOAD = CW'(PULSE_CYCLES);

   logic          meta_q;   // First sync stage, read only by sync_q
   logic          sync_q;   // Pin level in core_clk domain
   logic [CW-1:0] hold_q;   // Active-level duration count
   logic [CW-1:0] hold_d;
   logic          seen_q;   // Pulse already reported
   logic          seen_d;
   logic [CW-1:0] tx_q;     // Remaining drive cycles
   logic [CW-1:0] tx_d;

   // Active level is low, or high when inverted
   wire active   = ~(sync_q ^ invert);
   // Own drive is ignored so we never hear our own pulse
   wire count_on = listen & active & ~sending;
   wire at_last  = (hold_q == CNT_LAST);
   // R17: accept once width reached
   wire hit      = count_on & at_last & ~seen_q;

   // R17: width counter saturates
   assign hold_d = !count_on ? '0 : (at_last ? hold_q : hold_q + CW'(1));
   // R17: one event per pulse
   assign seen_d = count_on & (seen_q | hit);
   // R16: drive for the minimum width
   assign tx_d   = send ? CNT_LOAD : ((tx_q != '0) ? tx_q - CW'(1) : '0);

   assign level   = sync_q ^ invert;
   assign event_p = hit;
   assign sending = (tx_q != '0);

   // R17: two-stage synchroniser
   always_ff @(posedge core_clk)
   begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
   end

   // Counters and pulse memory
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         hold_q <= '0;
         seen_q <= 1'b0;
         tx_q   <= '0;
      end
      else
      begin
         hold_q <= hold_d;
         seen_q <= seen_d;
         tx_q   <= tx_d;
      end
   end

endmodule : sync_pin_filter

// File: sim/output_sync_sva.sv
`timescale 1ns/100ps
module output_sync_sva
   import io_sync_pkg::*;
#(
   parameter int unsigned PULSE_CYCLES = SYNC_LOW_MIN_CYC
)
(
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                reset,
   // Register writes
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [DATA_W-1:0]   reg_wdata,
   input  wire logic                reg_wr,
   // State and pins
   input  wire logic                out_on,
   input  wire logic [NUM_PINS-1:0] pin_i,
   input  wire logic [NUM_PINS-1:0] pin_o,
   input  wire logic [NUM_PINS-1:0] pin_oe,
   input  wire logic [NUM_PINS-1:0] gp_level
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   pin_cfg_t            cfg_q [NUM_PINS];  // Shadow of each pin setup
   logic [15:0]         wid_q [NUM_PINS];  // Cycles the pin has been driven
   logic [NUM_PINS-1:0] sync_v;            // Pin is in sync mode now
   logic [NUM_PINS-1:0] sync_q;            // Sync mode one cycle ago
   logic [NUM_PINS-1:0] inv_v;             // Polarity bits side by side

   assign sync_v = {cfg_q[1].mode == MODE_SYNC, cfg_q[0].mode == MODE_SYNC};
   assign inv_v  = {cfg_q[1].invert, cfg_q[0].invert};

   // Follow setup writes; time each drive pulse
   always_ff @(posedge core_clk)
   begin
      sync_q <= sync_v;
      for (int i = 0; i < NUM_PINS; i++)
      begin
         if (reset)
            cfg_q[i] <= CFG_RESET;
         else if (reg_wr && reg_addr == 8'(REG_CFG_BASE + CFG_STRIDE * i))
            cfg_q[i] <= pin_cfg_t'(reg_wdata[CFG_W-1:0]);
         wid_q[i] <= pin_oe[i] ? wid_q[i] + 16'h1 : 16'h0;
      end
   end

   // Steady level once setup has settled
   property p_drive(int i);
      cfg_q[i].mode == MODE_OUTPUT && !cfg_q[i].pwm_sel && $stable(cfg_q[i])
         |-> pin_oe[i] && pin_o[i] == !(cfg_q[i].level ^ cfg_q[i].invert);
   endproperty
   // Own pulse ends after exactly the filter width
   property p_width(int i);
      $fell(pin_oe[i]) && sync_v[i] && $past(sync_q[i]) |-> wid_q[i] == 16'(PULSE_CYCLES);
   endproperty

   a_drive_pin0 : assert property (p_drive(0))
      else $error("pin 0 steady level wrong");
   a_drive_pin1 : assert property (p_drive(1))
      else $error("pin 1 steady level wrong");
   a_width_on : assert property (p_width(0))
      else $error("turn-on pulse width wrong");
   a_width_off : assert property (p_width(1))
      else $error("turn-off pulse width wrong");
   a_input_quiet : assert property (
      cfg_q[0].mode == MODE_INPUT && $stable(cfg_q[0]) |-> !pin_oe[0])
      else $error("input pin is driven");
   a_on_pulse : assert property (
      $rose(out_on) && sync_v[0] |=> pin_oe[0] && pin_o[0] == cfg_q[0].invert)
      else $error("no turn-on pulse");
   a_off_pulse : assert property (
      $fell(out_on) && sync_v[1] |=> pin_oe[1] && pin_o[1] == cfg_q[1].invert)
      else $error("no turn-off pulse");
   a_on_cause : assert property (
      $rose(pin_oe[0]) && sync_v[0] |-> $past(out_on) && !$past(out_on, 2))
      else $error("turn-on pulse without change");
   a_off_cause : assert property (
      $rose(pin_oe[1]) && sync_v[1] |-> !$past(out_on) && $past(out_on, 2))
      else $error("turn-off pulse without change");
   a_input_level : assert property (
      $stable(inv_v) [*3] |-> gp_level == ($past(pin_i, 2) ^ inv_v))
      else $error("sampled level wrong");

   c_turn_on : cover property ($rose(out_on));
   c_turn_off : cover property ($fell(out_on));
   c_echo_off : cover property ($rose(pin_oe[1]) && sync_v[1]);

endmodule : output_sync_sva

// File: sim/sync_partner.sv
`timescale 1ns/100ps
module sync_partner
(
   // Clock
   input  wire logic       core_clk,
   // Wire levels and our drive
   input  wire logic [1:0] line,
   output logic      [1:0] drv_o,
   output logic      [1:0] drv_oe,
   // Pulses heard from the far end
   output logic [1:0][7:0] rx_cnt
);
   logic [1:0] line_q;  // Last sampled wire level

   initial drv_o  = 2'h0;
   initial drv_oe = 2'h0;
   initial rx_cnt = '0;

   // Count falls made by the far end only, not our own
   always @(posedge core_clk)
   begin
      line_q <= line;
      for (int i = 0; i < 2; i++)
         if (!drv_oe[i] && line_q[i] && !line[i])
            rx_cnt[i] <= rx_cnt[i] + 8'h1;
   end

   // hold low for the width asked; short only on purpose
   task send(input int i, input int len);
      @(posedge core_clk);
      drv_oe[i] <= 1'b1;
      repeat (len) @(posedge core_clk);
      drv_oe[i] <= 1'b0;
   endtask : send

endmodule : sync_partner

// File: sim/testbench.sv
`timescale 1ns/100ps
module testbench
   import io_sync_pkg::*;
;
   localparam int unsigned PC = 8;  // Short filter width keeps the run brief

   logic                core_clk = 1'b0;
   logic                reset = 1'b1;
   logic [ADDR_W-1:0]   reg_addr = '0;
   logic [DATA_W-1:0]   reg_wdata = '0;
   logic                reg_wr = 1'b0;
   logic                reg_rd = 1'b0;
   logic [DATA_W-1:0]   reg_rdata;
   logic                panel_on_req = 1'b0;
   logic                panel_off_req = 1'b0;
   logic                out_on;
   logic [NUM_PINS-1:0] pin_i, pin_o, pin_oe, gp_level, drv_o, drv_oe;
   logic [1:0][7:0]     rx_cnt;
   int                  fail_count = 0;
   int                  comparisons = 0;
   int                  n;

   always #2 core_clk = ~core_clk;
   // Open-drain wire with pull-up
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & (~drv_oe | drv_o));

   output_sync_io_pins #(.PULSE_CYCLES(PC)) dut (
      .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .panel_on_req(panel_on_req), .panel_off_req(panel_off_req), .out_on(out_on),
      .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .gp_level(gp_level));
   sync_partner p (.core_clk(core_clk), .line(pin_i), .drv_o(drv_o), .drv_oe(drv_oe),
      .rx_cnt(rx_cnt));

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task print_verdict;
      if (fail_count == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1 check("reg_rdata", reg_rdata, e);
   endtask : rd

   task panel(input logic on);
      @(posedge core_clk);
      panel_on_req  <= on;
      panel_off_req <= !on;
      @(posedge core_clk);
      panel_on_req  <= 1'b0;
      panel_off_req <= 1'b0;
   endtask : panel

   // Bounded wait for the output state
   task expect_on(input logic v);
      int k;
      k = 0;
      #1;
      while (out_on !== v && k < 40)
      begin
         @(posedge core_clk);
         #1;
         k++;
      end
      check("out_on", out_on, v);
      if (k == 40)
         print_verdict();
   endtask : expect_on

   task pulse(input int i, input int len, input logic v);
      p.send(i, len);
      repeat (PC + 4) @(posedge core_clk);
      expect_on(v);
   endtask : pulse

   initial
   begin
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      rd(REG_STATUS, 32'h6);
      for (int a = 4; a <= 24; a += 4)
         rd(8'(a), 32'h0);
      rd(8'h40, 32'h0);
      panel(1'b1);
      expect_on(1'b1);
      repeat (PC + 4) @(posedge core_clk);
      check("rx_on", rx_cnt[0], 8'h1);
      rd(REG_STATUS, 32'h7);
      pulse(0, 12, 1'b1);
      pulse(1, 12, 1'b0);
      pulse(1, 12, 1'b0);
      pulse(0, 4, 1'b0);
      pulse(0, 12, 1'b1);
      panel(1'b0);
      expect_on(1'b0);
      repeat (PC + 4) @(posedge core_clk);
      check("rx_off", rx_cnt[1], 8'h1);
      check("rx_on", rx_cnt[0], 8'h1);
      wr(REG_CFG_BASE, 32'h1);
      fork
         p.send(0, 20);
         begin
            repeat (8) @(posedge core_clk);
            rd(REG_STATUS, 32'h4);
         end
      join
      expect_on(1'b0);
      for (int i = 0; i < 2; i++)
         for (int k = 0; k < 4; k++)
         begin
            wr(8'(REG_CFG_BASE + CFG_STRIDE * i), 32'(k * 4 + 2));
            rd(8'(REG_CFG_BASE + CFG_STRIDE * i), 32'(k * 4 + 2));
            check("pin_oe", pin_oe[i], 1'b1);
            check("pin_o", pin_o[i], !(k[1] ^ k[0]));
         end
      wr(8'h14, 32'h4);
      wr(8'h08, 32'h12);
      for (int d = 1; d < 4; d += 2)
      begin
         wr(8'h18, 32'(d));
         repeat (4) @(posedge core_clk);
         n = 0;
         repeat (8)
         begin
            @(posedge core_clk);
            #1;
            if (pin_o[1] == 1'b0)
               n++;
         end
         check("pwm_low", n, 32'(2 * d));
      end
      print_verdict();
   end

   // Hang guard
   initial
   begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      print_verdict();
   end

endmodule : testbench

bind output_sync_io_pins output_sync_sva #(.PULSE_CYCLES(PULSE_CYCLES)) u_sva (
   .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .out_on(out_on), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
   .gp_level(gp_level));
